// [core/bfh_map.vh]
// constants for the burst flash host pin interface
`ifndef BFH_MAP_VH
`define BFH_MAP_VH
`define BFH_ADDR_W 19
`define BFH_DATA_W 32
`define BFH_HALF_W 16
`define BFH_LEN_4 2'h0
`define BFH_LEN_8 2'h1
`define BFH_LEN_32 2'h2
`define BFH_LEN_CONT 2'h3
`define BFH_LAT_DEFAULT 4'h3
`define BFH_BUSY_RST_CYC 8'h10
`define BFH_FIFO_DEPTH 32
`endif

// [core/bfh_fifo.v]
// parameterised fifo with valid/ready on both sides
`default_nettype none
module bfh_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire arst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg ready_reg;
    wire do_wr;
    wire do_rd;
    // ready is held in a flop so that it leaves the pin block straight from a register
    assign in_ready = ready_reg;
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            ready_reg <= 1'b1;
        end else if (flush) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            ready_reg <= 1'b1;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
                ready_reg <= (count_reg + 1'b1 != DEPTH[AW:0]);
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
                ready_reg <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [core/bfh_pins.v]
// device-side pin logic of a burst flash: address load, burst sequencing, width, flags
`include "bfh_map.vh"
`default_nettype none
module bfh_pins #(
    parameter ADDR_W = `BFH_ADDR_W,
    parameter DATA_W = `BFH_DATA_W,
    parameter DEPTH = `BFH_FIFO_DEPTH,
    parameter [3:0] LATENCY = `BFH_LAT_DEFAULT,
    parameter [7:0] RST_BUSY_CYC = `BFH_BUSY_RST_CYC,
    parameter [ADDR_W-1:0] PROT_LO_A = 19'h00000,
    parameter [ADDR_W-1:0] PROT_HI_A = 19'h03fff
) (
    input wire clk,
    input wire arst_n,
    input wire [ADDR_W-1:0] address_pins,
    input wire addr_lsb_pin,
    input wire width_full_pin,
    input wire chip_en_n,
    input wire out_en_n,
    input wire write_en_n,
    input wire address_load_n,
    input wire write_protect_n,
    input wire [1:0] burst_len,
    input wire [DATA_W-1:0] array_rd_data,
    input wire array_rd_valid,
    output wire array_rd_ready,
    output reg [ADDR_W-1:0] array_rd_addr,
    output reg array_rd_req,
    input wire algo_busy,
    input wire [ADDR_W-1:0] algo_addr,
    input wire algo_start,
    output reg algo_allow,
    output reg [DATA_W-1:0] data_pins_out,
    output reg [DATA_W-1:0] data_pins_oe,
    output reg burst_end_n,
    output reg wait_n,
    output reg ready_busy_n_out,
    output reg ready_busy_n_oe
);
    reg [4:0] ce_s_reg;
    reg [4:0] ce_s2_reg;
    wire ce_n_q;
    wire oe_n_q;
    wire we_n_q;
    wire adv_n_q;
    wire wp_n_q;
    wire full_q;
    wire lsb_q;
    reg [ADDR_W:0] a_s1_reg;
    reg [ADDR_W:0] a_s2_reg;
    reg [ADDR_W-1:0] base_reg;
    reg [5:0] fetch_cnt_reg;
    reg [5:0] out_cnt_reg;
    reg [5:0] len_words;
    reg half_reg;
    reg [3:0] lat_reg;
    reg active_reg;
    reg [7:0] rst_cnt_reg;
    wire fifo_ov;
    wire [DATA_W-1:0] fifo_od;
    wire fifo_pop;
    wire cont;
    wire last_out;
    wire [ADDR_W-1:0] word_addr;
    wire [DATA_W-1:0] half_sel;
    // two-flop synchronisers for strobes, width select and write protect
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ce_s_reg <= 5'h1f;
            ce_s2_reg <= 5'h1f;
            a_s1_reg <= {(ADDR_W+1){1'b0}};
            a_s2_reg <= {(ADDR_W+1){1'b0}};
        end else begin
            ce_s_reg <= {chip_en_n, out_en_n, write_en_n, address_load_n, write_protect_n};
            ce_s2_reg <= ce_s_reg;
            a_s1_reg <= {width_full_pin, address_pins};
            a_s2_reg <= a_s1_reg;
        end
    end
    reg lsb_s1_reg;
    reg lsb_s2_reg;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lsb_s1_reg <= 1'b0;
            lsb_s2_reg <= 1'b0;
        end else begin
            lsb_s1_reg <= addr_lsb_pin;
            lsb_s2_reg <= lsb_s1_reg;
        end
    end
    assign ce_n_q = ce_s2_reg[4];
    assign oe_n_q = ce_s2_reg[3];
    assign we_n_q = ce_s2_reg[2];
    assign adv_n_q = ce_s2_reg[1];
    assign wp_n_q = ce_s2_reg[0];
    assign full_q = a_s2_reg[ADDR_W];
    assign lsb_q = lsb_s2_reg;
    assign cont = (burst_len == `BFH_LEN_CONT);
    always @* begin
        case (burst_len)
            `BFH_LEN_4: len_words = 6'h04;
            `BFH_LEN_8: len_words = 6'h08;
            `BFH_LEN_32: len_words = 6'h20;
            default: len_words = 6'h3f;
        endcase
    end
    // finite bursts wrap inside the aligned window; continuous ones walk base_reg itself
    assign word_addr = cont ? base_reg :
        ((base_reg & ~{{(ADDR_W-6){1'b0}}, len_words - 6'h01}) |
        ((base_reg + {{(ADDR_W-6){1'b0}}, fetch_cnt_reg}) &
        {{(ADDR_W-6){1'b0}}, len_words - 6'h01}));
    // burst start, fetch and termination on the host clock
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_reg <= {ADDR_W{1'b0}};
            half_reg <= 1'b0;
            fetch_cnt_reg <= 6'h00;
            active_reg <= 1'b0;
            lat_reg <= 4'h0;
            array_rd_addr <= {ADDR_W{1'b0}};
            array_rd_req <= 1'b0;
        end else if (ce_n_q || !we_n_q) begin
            active_reg <= 1'b0;
            array_rd_req <= 1'b0;
        end else if (!adv_n_q) begin
            base_reg <= a_s2_reg[ADDR_W-1:0];
            half_reg <= !full_q ? lsb_q : 1'b0;
            fetch_cnt_reg <= 6'h00;
            active_reg <= 1'b1;
            lat_reg <= LATENCY;
            array_rd_req <= 1'b0;
        end else if (active_reg) begin
            if (lat_reg != 4'h0) begin
                lat_reg <= lat_reg - 4'h1;
                array_rd_req <= 1'b0;
            end else if ((cont || fetch_cnt_reg != len_words) && array_rd_ready) begin
                array_rd_addr <= word_addr;
                array_rd_req <= 1'b1;
                fetch_cnt_reg <= fetch_cnt_reg + 6'h01;
                if (cont) begin
                    // a full-width step avoids the 64-word wrap of the fetch counter
                    base_reg <= base_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                end
            end else begin
                array_rd_req <= 1'b0;
            end
        end else begin
            array_rd_req <= 1'b0;
        end
    end
    // data buffered toward the pins; a full buffer stalls further fetches
    bfh_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .flush(ce_n_q || !adv_n_q),
        .in_valid(array_rd_valid),
        .in_ready(array_rd_ready),
        .in_data(array_rd_data),
        .out_valid(fifo_ov),
        .out_ready(fifo_pop),
        .out_data(fifo_od)
    );
    // host reads with chip and output enable low, write enable high
    assign fifo_pop = fifo_ov && !ce_n_q && !oe_n_q && we_n_q && adv_n_q;
    assign last_out = !cont && (out_cnt_reg == len_words - 6'h01);
    assign half_sel = half_reg ? {{(DATA_W-16){1'b0}}, fifo_od[DATA_W-1:16]} : fifo_od;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_cnt_reg <= 6'h00;
            data_pins_out <= {DATA_W{1'b0}};
            data_pins_oe <= {DATA_W{1'b0}};
            burst_end_n <= 1'b1;
            wait_n <= 1'b1;
        end else begin
            if (!adv_n_q || ce_n_q) begin
                out_cnt_reg <= 6'h00;
            end else if (fifo_pop) begin
                out_cnt_reg <= out_cnt_reg + 6'h01;
            end
            if (fifo_pop) begin
                data_pins_out <= full_q ? fifo_od : half_sel;
                burst_end_n <= !last_out;
            end else if (!adv_n_q || ce_n_q) begin
                burst_end_n <= 1'b1;
            end
            wait_n <= cont ? fifo_pop : 1'b1;
            if (ce_n_q || oe_n_q || !we_n_q) begin
                data_pins_oe <= {DATA_W{1'b0}};
            end else if (full_q) begin
                data_pins_oe <= {DATA_W{1'b1}};
            end else begin
                data_pins_oe <= {{(DATA_W-16){1'b0}}, 16'hffff};
            end
        end
    end
    // write protect of the one low address range PROT_LO_A to PROT_HI_A and ready/busy reporting
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_reg <= 8'h00;
            algo_allow <= 1'b0;
            ready_busy_n_out <= 1'b0;
            ready_busy_n_oe <= 1'b1;
        end else begin
            if (rst_cnt_reg != RST_BUSY_CYC) begin
                rst_cnt_reg <= rst_cnt_reg + 8'h01;
            end
            algo_allow <= algo_start &&
                !(!wp_n_q && algo_addr >= PROT_LO_A && algo_addr <= PROT_HI_A);
            ready_busy_n_out <= 1'b0;
            ready_busy_n_oe <= algo_busy || (rst_cnt_reg != RST_BUSY_CYC);
        end
    end
endmodule
`default_nettype wire

// [testbench/bfh_pins_properties.sv]
// checker of the burst flash pin logic, bound to its top module
`default_nettype none
module bfh_pins_properties #(
    parameter ADDR_W = 19,
    parameter DATA_W = 32,
    parameter [ADDR_W-1:0] PROT_HI_A = 19'h03fff
) (
    input wire clk,
    input wire arst_n,
    input wire width_full_pin,
    input wire chip_en_n,
    input wire write_protect_n,
    input wire [1:0] burst_len,
    input wire algo_busy,
    input wire [ADDR_W-1:0] algo_addr,
    input wire algo_start,
    input wire algo_allow,
    input wire [DATA_W-1:0] data_pins_oe,
    input wire burst_end_n,
    input wire wait_n,
    input wire ready_busy_n_out,
    input wire ready_busy_n_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_half; !width_full_pin [*5] |-> data_pins_oe[31:16] == 16'h0000; endproperty
    a_half: assert property (p_half) else $error("upper data pins driven in half width");
    property p_desel; chip_en_n [*5] |-> data_pins_oe == 32'h00000000; endproperty
    a_desel: assert property (p_desel) else $error("data pins driven while deselected");
    property p_fin_wait; (burst_len != 2'h3) [*2] |-> wait_n; endproperty
    a_fin_wait: assert property (p_fin_wait) else $error("wait low in finite burst");
    property p_od; ready_busy_n_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("ready busy drives high");
    property p_rst_busy; $rose(arst_n) |-> ready_busy_n_oe [*8]; endproperty
    a_rst_busy: assert property (p_rst_busy) else $error("ready after reset too soon");
    property p_algo_busy; algo_busy [*2] |-> ready_busy_n_oe; endproperty
    a_algo_busy: assert property (p_algo_busy) else $error("ready during algorithm");
    property p_prot;
        !write_protect_n [*4] ##0 (algo_start && algo_addr <= PROT_HI_A) |=> !algo_allow;
    endproperty
    a_prot: assert property (p_prot) else $error("protected sector allowed");
    property p_open; write_protect_n [*4] ##0 algo_start |=> algo_allow; endproperty
    a_open: assert property (p_open) else $error("unprotected request refused");
    property p_cause; algo_allow |-> $past(algo_start); endproperty
    a_cause: assert property (p_cause) else $error("allow without request");
    c_end: cover property (!burst_end_n);
    c_wait: cover property (burst_len == 2'h3 && $fell(wait_n));
    c_allow: cover property (algo_allow);
endmodule
`default_nettype wire

// [testbench/bfh_array_model.sv]
// array model answering fetch requests, promptly or slowly
`default_nettype none
module bfh_array_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic array_rd_req,
    input wire logic [18:0] array_rd_addr,
    input wire logic array_rd_ready,
    output logic array_rd_valid,
    output logic [31:0] array_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [18:0] q[$];
    int gap;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q.delete();
            gap = 0;
            array_rd_valid <= 1'b0;
            array_rd_data <= 32'h00000000;
        end else begin
            if (array_rd_req)
                q.push_back(array_rd_addr);
            gap++;
            if (array_rd_valid && array_rd_ready) begin
                array_rd_valid <= 1'b0;
                array_rd_data <= ~array_rd_data;
                gap = 0;
            end else if (!array_rd_valid && q.size() > 0 && gap > (slow ? 3 : 0)) begin
                array_rd_valid <= 1'b1;
                array_rd_data <= {q[0][15:0] ^ 16'h5a5a, q[0][15:0]};
                void'(q.pop_front());
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/bfh_pins_tb.sv]
// self-checking bench of the burst flash pin logic
`default_nettype none
module bfh_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, arst_n = 0, lsb = 0, wfull = 1, ce_n = 1, oe_n = 1, we_n = 1, ld_n = 1;
    logic wp_n = 1, a_busy = 0, a_start = 0, slow = 0;
    logic [1:0] blen = 2'h0;
    logic [18:0] addr = 19'h0, a_addr = 19'h0, rd_addr, last, first;
    logic rd_valid, rd_ready, rd_req, allow, end_n, wait_n, rb_out, rb_oe;
    logic [31:0] rd_data, dout, doe, w, r, seed;
    int mismatches = 0, check_count = 0, i, k, n, cnt, hi, lo, hf;
    bfh_pins dut_u (.clk(clk), .arst_n(arst_n), .address_pins(addr), .addr_lsb_pin(lsb),
        .width_full_pin(wfull), .chip_en_n(ce_n), .out_en_n(oe_n), .write_en_n(we_n),
        .address_load_n(ld_n), .write_protect_n(wp_n), .burst_len(blen),
        .array_rd_data(rd_data), .array_rd_valid(rd_valid), .array_rd_ready(rd_ready),
        .array_rd_addr(rd_addr), .array_rd_req(rd_req), .algo_busy(a_busy),
        .algo_addr(a_addr), .algo_start(a_start), .algo_allow(allow), .data_pins_out(dout),
        .data_pins_oe(doe), .burst_end_n(end_n), .wait_n(wait_n),
        .ready_busy_n_out(rb_out), .ready_busy_n_oe(rb_oe));
    bfh_array_model arr_u (.clk(clk), .arst_n(arst_n), .slow(slow), .array_rd_req(rd_req),
        .array_rd_addr(rd_addr), .array_rd_ready(rd_ready), .array_rd_valid(rd_valid),
        .array_rd_data(rd_data));
    always #10 clk = ~clk;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            first <= 19'h7ffff;
        end else begin
            cnt <= cnt + (rd_valid && rd_ready);
            if (rd_req && first == 19'h7ffff)
                first <= rd_addr;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] xs;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask
    task automatic rst;
        arst_n = 0;
        cyc(6);
        arst_n = 1;
    endtask
    task automatic burst(input logic [18:0] a, input logic [1:0] bl, input logic f, h, o);
        rst;
        cyc(20);
        blen = bl;
        wfull = f;
        lsb = h;
        addr = a;
        ce_n = 0;
        ld_n = 0;
        cyc(3);
        ld_n = 1;
        oe_n = o;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
    initial begin
        seed = 16466;
        rst;
        chk("busy_rst", rb_oe, 1);
        cyc(20);
        chk("busy_idle", rb_oe, 0);
        a_busy = 1;
        cyc(3);
        chk("busy_algo", rb_oe, 1);
        a_busy = 0;
        for (i = 0; i < 3; i++) begin
            r = xs();
            wp_n = (i == 1);
            a_addr = (i == 2) ? {1'b1, r[17:0]} : {5'h00, r[13:0]};
            cyc(5);
            a_start = 1;
            cyc(1);
            chk("allow", allow, i != 0);
            a_start = 0;
        end
        for (i = 0; i < 4; i++) begin
            r = xs();
            n = (i == 3) ? 32 : (i == 2) ? 8 : 4;
            hf = (i == 1 || i == 3);
            burst(r[18:0], 2'(i == 3 ? 2 : i == 2), !hf, i == 1, 0);
            last = 19'((r[18:0] & ~(n - 1)) | ((r[18:0] + n - 1) & (n - 1)));
            for (k = 0; k < 300 && end_n !== 1'b0; k++)
                cyc(1);
            w = {last[15:0] ^ 16'h5a5a, last[15:0]};
            chk("end", end_n, 0);
            chk("wait_fin", wait_n, 1);
            chk("oe", doe, hf ? 32'h0000ffff : 32'hffffffff);
            chk("data", hf ? {16'h0, dout[15:0]} : dout,
                i == 1 ? w >> 16 : i == 3 ? w & 32'h0000ffff : w);
        end
        burst(19'h00100, 2'h3, 1, 0, 1);
        for (k = 0; k < 400 && rd_ready !== 1'b0; k++)
            cyc(1);
        chk("fill", cnt, 32);
        chk("first", first, 19'h00100);
        slow = 1;
        oe_n = 0;
        hi = 0;
        lo = 0;
        for (k = 0; k < 300; k++) begin
            cyc(1);
            hi += (wait_n === 1'b1);
            lo += (wait_n === 1'b0);
            chk("end_cont", end_n, 1);
        end
        chk("wait_hi", hi > 0, 1);
        chk("wait_lo", lo > 0, 1);
        ce_n = 1;
        cyc(5);
        chk("desel", doe, 0);
        wrap_up;
    end
endmodule
bind bfh_pins bfh_pins_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .PROT_HI_A(PROT_HI_A))
    chk_u (.clk(clk), .arst_n(arst_n), .width_full_pin(width_full_pin),
    .chip_en_n(chip_en_n), .write_protect_n(write_protect_n), .burst_len(burst_len),
    .algo_busy(algo_busy), .algo_addr(algo_addr), .algo_start(algo_start),
    .algo_allow(algo_allow), .data_pins_oe(data_pins_oe), .burst_end_n(burst_end_n),
    .wait_n(wait_n), .ready_busy_n_out(ready_busy_n_out), .ready_busy_n_oe(ready_busy_n_oe));
`default_nettype wire
